// >>> rvc_top.sv
// Regulator mode selection, voltage code decode, fault protection and register slave
`timescale 1ns/1ns
module rvc_top #(
	parameter int VOLT_QUAL = rvc_pkg::VOLT_QUAL_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] voltage_code,
	input wire logic deep_stop_n,
	input wire logic extra_efficiency_sel,
	input wire logic deeper_sleep_req,
	input wire logic switch_period_tick,
	input wire logic regulator_on,
	input wire logic pwm_high_req,
	input wire logic ls_current_reversed,
	input wire logic near_target,
	input wire logic oc_cmp,
	input wire logic woc_cmp,
	input wire logic ov_cmp,
	input wire logic uv_cmp,
	input wire logic wov_above_cmp,
	input wire logic wov_below_cmp,
	input wire logic thermistor_low,
	output logic [20:0] target_uv,
	output logic diode_emulation,
	output logic enhanced_diode_emulation,
	output logic forced_continuous_conduction,
	output logic window_boost,
	output logic fast_slew,
	output logic slew_taper,
	output logic hs_gate_out,
	output logic hs_gate_oe,
	output logic ls_gate_out,
	output logic ls_gate_oe,
	output logic power_good_out,
	output logic thermal_throttle_n,
	output logic irq
);
	import rvc_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////
	// Voltage code decode
	wire code_is_zero_volt = voltage_code >= CODE_ZERO_START;
	wire [6:0] code_steps = code_is_zero_volt ? 7'h00 : CODE_TOP_STEPS - voltage_code;
	wire [20:0] target_next = 21'(code_steps) * STEP_UV;
	logic [20:0] target_uv_reg;
	logic [6:0] steps_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			target_uv_reg <= 21'h000000;
			steps_reg <= 7'h00;
		end else begin
			target_uv_reg <= target_next;
			steps_reg <= code_steps;
		end
	end
	assign target_uv = target_uv_reg;

	chk_zero_code: assert property (code_is_zero_volt |=> target_uv_reg == 21'h000000)
		else $error("zero-volt code did not give 0 V");
	chk_step_size: assert property (voltage_code == 7'h77 |=> target_uv_reg == STEP_UV)
		else $error("last nonzero code is not one step");
	// Sampled reset keeps the release edge, where the register still reads zero, out
	chk_top_code: assert property (rst_b && voltage_code == 7'h00
		|=> target_uv_reg == TOP_UV)
		else $error("all-zero code is not 1.5 V");

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and glitch filter counted in switching periods
	rvc_mode_t raw_mode;
	rvc_mode_t mode_reg;
	rvc_mode_t pend_reg;
	logic [FILT_W-1:0] filt_cnt_reg;
	logic [FILT_W-1:0] filt_cnt_next;

	assign raw_mode = deep_stop_n ? RVC_CCM :
		extra_efficiency_sel ? RVC_ENHANCED_DIODE_EMULATION :
		deeper_sleep_req ? RVC_DEM : RVC_CCM;

	wire filt_done = switch_period_tick && (filt_cnt_reg == FILT_W'(FILTER_PERIODS - 1));
	wire mode_commit = (raw_mode == pend_reg) && (pend_reg != mode_reg) && filt_done;
	// Any change of the decoded mode restarts the count, so short glitches never commit
	assign filt_cnt_next = (raw_mode != pend_reg) ? '0 :
		(switch_period_tick && filt_cnt_reg != FILT_W'(FILTER_PERIODS - 1)) ?
		filt_cnt_reg + 1'b1 : filt_cnt_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= RVC_CCM;
			pend_reg <= RVC_CCM;
			filt_cnt_reg <= '0;
		end else begin
			pend_reg <= raw_mode;
			filt_cnt_reg <= filt_cnt_next;
			if (mode_commit) begin
				mode_reg <= pend_reg;
			end
		end
	end

	assign diode_emulation = mode_reg == RVC_DEM;
	assign enhanced_diode_emulation = mode_reg == RVC_ENHANCED_DIODE_EMULATION;
	assign forced_continuous_conduction = mode_reg == RVC_CCM;
	assign window_boost = mode_reg == RVC_ENHANCED_DIODE_EMULATION;

	sequence s_pins_stable;
		raw_mode == pend_reg;
	endsequence
	chk_mode_filter: assert property (mode_reg != $past(mode_reg)
		|-> $past(filt_cnt_reg) == FILT_W'(FILTER_PERIODS - 1) && $past(switch_period_tick))
		else $error("mode changed before filter count elapsed");
	chk_mode_target: assert property (s_pins_stable ##1 (mode_reg != $past(mode_reg))
		|-> mode_reg == $past(pend_reg))
		else $error("mode committed to wrong combination");
	chk_enhanced_diode_emulation_window: assert property ($rose(window_boost)
		|-> !$past(deep_stop_n) && $past(extra_efficiency_sel))
		else $error("window boost without enhanced-mode pins");

	////////////////////////////////////////////////////////////////////////////
	// Slew path selection
	logic fast_slew_reg;
	logic slew_taper_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fast_slew_reg <= 1'b0;
			slew_taper_reg <= 1'b0;
		end else begin
			fast_slew_reg <= !deeper_sleep_req;
			slew_taper_reg <= near_target;
		end
	end
	assign fast_slew = fast_slew_reg;
	assign slew_taper = slew_taper_reg;

	chk_slew_sel: assert property (deeper_sleep_req |=> !fast_slew)
		else $error("slow slew not selected in deeper sleep");
	chk_taper: assert property (near_target |=> slew_taper)
		else $error("slew did not taper near target");

	////////////////////////////////////////////////////////////////////////////
	// Fault qualification and latches
	logic on_prev_reg;
	wire on_toggle = regulator_on != on_prev_reg;
	wire [NUM_FAULTS-1:0] fault_cond = {uv_cmp, ov_cmp, woc_cmp, oc_cmp};
	localparam logic [QUAL_W-1:0] FAULT_LIM [NUM_FAULTS] = '{QUAL_W'(OC_QUAL_CYC),
		QUAL_W'(WOC_QUAL_CYC), QUAL_W'(VOLT_QUAL), QUAL_W'(VOLT_QUAL)};
	logic [QUAL_W-1:0] fcnt_reg [NUM_FAULTS];
	logic [NUM_FAULTS-1:0] fault_lat_reg;
	logic [NUM_FAULTS-1:0] fault_set;
	logic [NUM_FAULTS-1:0] fault_lat_next;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			on_prev_reg <= 1'b0;
			fault_lat_reg <= '0;
		end else begin
			on_prev_reg <= regulator_on;
			fault_lat_reg <= fault_lat_next;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_fault
			assign fault_set[gi] = fault_cond[gi] && (fcnt_reg[gi] == FAULT_LIM[gi] - 1'b1);
			// A fault qualifying in the toggle cycle still latches
			assign fault_lat_next[gi] = fault_set[gi] ||
				(fault_lat_reg[gi] && !on_toggle);
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					fcnt_reg[gi] <= '0;
				end else begin
					// Count only while the condition persists, saturating one below the limit
					if (!fault_cond[gi]) begin
						fcnt_reg[gi] <= '0;
					end else if (fcnt_reg[gi] != FAULT_LIM[gi] - 1'b1) begin
						fcnt_reg[gi] <= fcnt_reg[gi] + 1'b1;
					end
				end
			end
		end
	endgenerate

	chk_oc_qual: assert property ($rose(fault_lat_reg[F_OC])
		|-> $past(fcnt_reg[F_OC]) == QUAL_W'(OC_QUAL_CYC - 1) && $past(oc_cmp))
		else $error("overcurrent latched without full qualification");
	chk_woc_fast: assert property (woc_cmp [*8] ##0 (fcnt_reg[F_WOC] == QUAL_W'(WOC_QUAL_CYC - 1))
		|=> fault_lat_reg[F_WOC])
		else $error("way-overcurrent not latched in time");
	chk_fault_clear: assert property (on_toggle && fault_set == '0 |=> fault_lat_reg == '0)
		else $error("fault latch survived regulator-on toggle");
	chk_fault_hold: assert property (fault_lat_reg[F_OV] && !on_toggle |=> fault_lat_reg[F_OV])
		else $error("overvoltage latch cleared without toggle");

	////////////////////////////////////////////////////////////////////////////
	// Way-overvoltage crowbar, always active
	rvc_wov_t wov_reg;
	rvc_wov_t wov_next;
	logic wov_lat_reg;

	always_comb begin
		wov_next = wov_reg;
		unique case (wov_reg)
			RVC_WOV_IDLE: begin
				if (wov_above_cmp) begin
					wov_next = RVC_WOV_DISCHARGE;
				end
			end
			RVC_WOV_DISCHARGE: begin
				if (wov_below_cmp) begin
					wov_next = RVC_WOV_OFF;
				end
			end
			RVC_WOV_OFF: begin
				// Re-arms so a leaking high-side switch is caught again
				if (wov_above_cmp) begin
					wov_next = RVC_WOV_DISCHARGE;
				end
			end
			default: begin
				wov_next = RVC_WOV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wov_reg <= RVC_WOV_IDLE;
			wov_lat_reg <= 1'b0;
		end else begin
			wov_reg <= wov_next;
			if (wov_above_cmp) begin
				wov_lat_reg <= 1'b1;
			end
		end
	end

	wire wov_dis = wov_reg == RVC_WOV_DISCHARGE;
	wire any_fault = (|fault_lat_reg) || wov_lat_reg;

	chk_wov_entry: assert property (wov_above_cmp |=> wov_reg == RVC_WOV_DISCHARGE
		##1 (ls_gate_oe && ls_gate_out && !hs_gate_out))
		else $error("crowbar did not turn on the low-side switch");
	chk_wov_sticky: assert property (wov_lat_reg |=> wov_lat_reg)
		else $error("way-overvoltage latch cleared without reset");

	////////////////////////////////////////////////////////////////////////////
	// Gate drive, power good and thermal throttle
	wire run = regulator_on && !any_fault;
	wire dem_any = mode_reg != RVC_CCM;
	logic hs_out_reg;
	logic hs_oe_reg;
	logic ls_out_reg;
	logic ls_oe_reg;
	logic pg_reg;
	logic tt_n_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hs_out_reg <= 1'b0;
			hs_oe_reg <= 1'b0;
			ls_out_reg <= 1'b0;
			ls_oe_reg <= 1'b0;
			pg_reg <= 1'b0;
			tt_n_reg <= 1'b1;
		end else begin
			hs_out_reg <= run && !wov_dis && pwm_high_req;
			hs_oe_reg <= run || wov_dis;
			ls_out_reg <= wov_dis ||
				(run && !pwm_high_req && !(dem_any && ls_current_reversed));
			ls_oe_reg <= run || wov_dis;
			pg_reg <= run;
			tt_n_reg <= !thermistor_low;
		end
	end
	assign hs_gate_out = hs_out_reg;
	assign hs_gate_oe = hs_oe_reg;
	assign ls_gate_out = ls_out_reg;
	assign ls_gate_oe = ls_oe_reg;
	assign power_good_out = pg_reg;
	assign thermal_throttle_n = tt_n_reg;

	chk_fault_tristate: assert property ((|fault_lat_reg) && !wov_dis
		|=> !hs_gate_oe && !ls_gate_oe && !power_good_out)
		else $error("gates driven or power good high during fault");
	chk_dem_reverse: assert property (run && !wov_dis && dem_any && ls_current_reversed
		|=> !ls_gate_out)
		else $error("low-side on with reversed current in emulation");
	chk_throttle: assert property (thermistor_low && !any_fault |=> !thermal_throttle_n
		&& power_good_out == $past(run))
		else $error("thermal throttle wrong or caused other action");

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	logic [NUM_EVENTS-1:0] status_reg;
	logic [NUM_EVENTS-1:0] mask_reg;
	logic therm_prev_reg;
	wire [NUM_EVENTS-1:0] ev_pulse = {mode_commit, thermistor_low && !therm_prev_reg,
		wov_above_cmp && !wov_lat_reg, fault_set & ~fault_lat_reg};

	////////////////////////////////////////////////////////////////////////////
	// Register slave
	logic aw_got_reg;
	logic w_got_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
	wire wr_status = do_write && awaddr_reg == ADDR_STATUS && wstrb_reg[0];
	wire wr_mask = do_write && awaddr_reg == ADDR_MASK && wstrb_reg[0];
	wire wr_ok = awaddr_reg == ADDR_STATUS || awaddr_reg == ADDR_MASK;
	wire [NUM_EVENTS-1:0] w1c = wr_status ? wdata_reg[NUM_EVENTS-1:0] : '0;
	wire rd_take = s_axi_arvalid && !rvalid_reg;
	wire [31:0] state_word = {17'h00000, steps_reg, pg_reg, mode_reg, wov_lat_reg, fault_lat_reg};
	wire rd_ok = s_axi_araddr == ADDR_STATUS || s_axi_araddr == ADDR_MASK
		|| s_axi_araddr == ADDR_STATE;
	wire [31:0] rd_word = s_axi_araddr == ADDR_STATUS ? 32'(status_reg) :
		s_axi_araddr == ADDR_MASK ? 32'(mask_reg) :
		s_axi_araddr == ADDR_STATE ? state_word : 32'h00000000;

	assign s_axi_awready = !aw_got_reg;
	assign s_axi_wready = !w_got_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = |(status_reg & mask_reg);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_got_reg) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_reg) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= '0;
			mask_reg <= MASK_RESET;
			therm_prev_reg <= 1'b0;
		end else begin
			// New events win over a same-cycle clear
			status_reg <= (status_reg & ~w1c) | ev_pulse;
			therm_prev_reg <= thermistor_low;
			if (wr_mask) begin
				mask_reg <= wdata_reg[NUM_EVENTS-1:0];
			end
		end
	end

	chk_irq_level: assert property ((status_reg & mask_reg) != '0 |-> irq)
		else $error("interrupt low with an unmasked event");
	chk_event_sticky: assert property (ev_pulse != '0
		|=> (status_reg & $past(ev_pulse)) == $past(ev_pulse))
		else $error("interrupt status lost an event");
endmodule

// >>> rvc_pkg.sv
// Constants, types and register map of the regulator mode and fault controller
// Overview of operation
// - Each code step lowers target 12.5 mV; codes 0x78 and above give 0 V.
// - After startup the all-zero code regulates to 1.5 V, range top.
// - Deep-stop low, extra-efficiency low, deeper-sleep high: diode emulation, no window boost.
// - Deep-stop low, extra-efficiency high: enhanced diode emulation, window widened one third.
// - Every other mode input combination runs forced continuous conduction.
// - Mode inputs lasting under seven switching periods never enable diode emulation.
// - Deeper-sleep low selects the fast slew path.
// - Deeper-sleep high selects the slow slew path.
// - Slew rate tapers as the output nears the commanded code value.
// - Overcurrent qualifies 120 us, way-overcurrent under 2 us, over/undervoltage 1 ms.
// - Any qualified fault tri-states both gates and latches power good low.
// - Those fault latches clear only by regulator-on toggle or supply cycling.
// - Above 1.7 V low-side on until below 0.85 V, then off; reset-only clear.
// - Droop above twice the threshold trips the short way-overcurrent qualification.
// - Thermistor below threshold asserts thermal throttle and sets its interrupt status event, nothing else.
package rvc_pkg;
	typedef enum logic [1:0] {
		RVC_CCM,
		RVC_DEM,
		RVC_ENHANCED_DIODE_EMULATION
	} rvc_mode_t;

	typedef enum logic [1:0] {
		RVC_WOV_IDLE,
		RVC_WOV_DISCHARGE,
		RVC_WOV_OFF
	} rvc_wov_t;

	localparam int CLK_PERIOD_NS = 50;
	localparam int OC_QUAL_NS = 120000;
	localparam int WOC_QUAL_NS = 2000;
	localparam int VOLT_QUAL_NS = 1000000;
	localparam int OC_QUAL_CYC = (OC_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Two cycles short so the gates are already off strictly before 2 us
	localparam int WOC_QUAL_CYC = WOC_QUAL_NS / CLK_PERIOD_NS - 2;
	localparam int VOLT_QUAL_CYC = (VOLT_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_PERIODS = 7;
	localparam int QUAL_W = 16;
	localparam int FILT_W = 4;

	localparam logic [6:0] CODE_ZERO_START = 7'h78;
	localparam logic [6:0] CODE_TOP_STEPS = 7'h78;
	localparam logic [20:0] STEP_UV = 21'h030D4;
	localparam logic [20:0] TOP_UV = 21'h16E360;

	localparam int NUM_FAULTS = 4;
	localparam int F_OC = 0;
	localparam int F_WOC = 1;
	localparam int F_OV = 2;
	localparam int F_UV = 3;

	localparam int NUM_EVENTS = 7;
	localparam int EV_WOV = 4;
	localparam int EV_THERM = 5;
	localparam int EV_MODE = 6;

	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h4;
	localparam logic [3:0] ADDR_STATE = 4'h8;
	localparam logic [6:0] MASK_RESET = 7'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rvc_far_side.sv
// Far-side model: processor mode pins and the switching-period clock of the stage
`timescale 1ns/1ns
module rvc_far_side #(
	parameter int TICK_P = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] sel,
	input wire logic cpu_stop_n,
	input wire logic cpu_sleep,
	input wire logic raw_fde,
	output logic deep_stop_n,
	output logic extra_efficiency_sel,
	output logic deeper_sleep_req,
	output logic switch_period_tick
);
	logic [7:0] cnt_reg;
	////////////////////////////////////////////////////////////////////////////
	// Period tick; a short period keeps the filter counts quick to walk through
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= (cnt_reg == 8'(TICK_P - 1)) ? 8'h00 : cnt_reg + 8'h01;
		end
	end
	assign switch_period_tick = rst_b && (cnt_reg == 8'(TICK_P - 1));
	////////////////////////////////////////////////////////////////////////////
	// Wiring options: 0 raw pins, 1 efficiency follows sleep, 2 enhanced held
	assign deep_stop_n = (sel == 2'h2) ? 1'b0 : cpu_stop_n;
	assign extra_efficiency_sel = (sel == 2'h1) ? cpu_sleep : (sel == 2'h2) | raw_fde;
	assign deeper_sleep_req = cpu_sleep;
endmodule

// >>> rvc_top_test.sv
// Self-checking testbench of the regulator mode and fault controller
`timescale 1ns/1ns
module rvc_top_test;
	import rvc_pkg::*;
	localparam int VQ = 50;
	logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, f;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [6:0] voltage_code;
	logic [1:0] sel, s_axi_bresp, s_axi_rresp;
	logic [20:0] target_uv;
	logic cpu_stop_n, cpu_sleep, raw_fde, regulator_on, pwm_high_req, ls_current_reversed;
	logic near_target, wov_above_cmp, wov_below_cmp, thermistor_low;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic diode_emulation, enhanced_diode_emulation, forced_continuous_conduction, window_boost;
	logic fast_slew, slew_taper, hs_gate_out, hs_gate_oe, ls_gate_out, ls_gate_oe, irq;
	logic power_good_out, thermal_throttle_n;
	logic deep_stop_n, extra_efficiency_sel, deeper_sleep_req, switch_period_tick;
	logic [3:0] mv;
	int err_total, samples_checked;
	int qn[4];
	rvc_top #(.VOLT_QUAL(VQ)) uut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .voltage_code, .deep_stop_n, .extra_efficiency_sel,
		.deeper_sleep_req, .switch_period_tick, .regulator_on, .pwm_high_req, .ls_current_reversed,
		.near_target, .oc_cmp(f[0]), .woc_cmp(f[1]), .ov_cmp(f[2]), .uv_cmp(f[3]), .wov_above_cmp,
		.wov_below_cmp, .thermistor_low, .target_uv, .diode_emulation, .enhanced_diode_emulation,
		.forced_continuous_conduction, .window_boost, .fast_slew, .slew_taper, .hs_gate_out,
		.hs_gate_oe, .ls_gate_out, .ls_gate_oe, .power_good_out, .thermal_throttle_n, .irq);
	rvc_far_side #(.TICK_P(4)) far (.clk, .rst_b, .sel, .cpu_stop_n, .cpu_sleep, .raw_fde,
		.deep_stop_n, .extra_efficiency_sel, .deeper_sleep_req, .switch_period_tick);
	assign mv = {diode_emulation, enhanced_diode_emulation, forced_continuous_conduction, window_boost};
	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hang();
		err_total++;
		end_of_test();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ha, hw, hb;
		logic [1:0] r;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) hang();
		chk(r, er);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		logic ha, hr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) hang();
		chk(d & m, ed);
		chk(r, er);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Counts period ticks, then lets the commit edge settle
	task automatic ticks(input int n);
		int k;
		int g;
		k = 0;
		for (g = 0; g < 400 && k < n; g++) begin
			@(negedge clk);
			if (switch_period_tick) k++;
		end
		if (k < n) hang();
		cyc(1);
	endtask
	// Pins change at a tick edge so the filter count starts from a known phase
	task automatic set_mode(input logic [1:0] s, input logic [2:0] p);
		ticks(1);
		sel <= s;
		cpu_stop_n <= p[2];
		raw_fde <= p[1];
		cpu_sleep <= p[0];
	endtask
	function automatic logic [3:0] mexp(input logic [2:0] p);
		if (!p[2] && p[1]) return 4'h5;
		if (!p[2] && p[0]) return 4'h8;
		return 4'h2;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic t_decode();
		logic [6:0] c[6] = '{7'h00, 7'h01, 7'h50, 7'h77, 7'h78, 7'h7F};
		foreach (c[i]) begin
			@(posedge clk);
			voltage_code <= c[i];
			cyc(2);
			chk(target_uv, (c[i] >= 7'h78) ? 0 : 1500000 - 12500 * c[i]);
		end
	endtask
	task automatic t_modes();
		logic [3:0] prev;
		prev = 4'h2;
		for (int i = 0; i < 8; i++) begin
			set_mode(2'h0, 3'(i));
			ticks(6);
			chk(mv, prev);
			ticks(1);
			chk(mv, mexp(3'(i)));
			chk(fast_slew, !i[0]);
			prev = mexp(3'(i));
		end
		wr(ADDR_STATUS, 32'h7F, RESP_OKAY);
		set_mode(2'h0, 3'h1);
		ticks(5);
		set_mode(2'h0, 3'h4);
		ticks(8);
		chk(mv, 4'h2);
		rdc(ADDR_STATUS, 32'h40, 32'h0, RESP_OKAY);
		set_mode(2'h1, 3'h1);
		ticks(8);
		chk(mv, 4'h5);
		rdc(ADDR_STATUS, 32'h40, 32'h40, RESP_OKAY);
		set_mode(2'h2, 3'h4);
		ticks(8);
		chk(mv, 4'h5);
		chk(fast_slew, 1'b1);
	endtask
	task automatic t_diode();
		set_mode(2'h0, 3'h1);
		ticks(8);
		pwm_high_req <= 1'b1;
		cyc(2);
		chk({hs_gate_out, ls_gate_out}, 2'h2);
		pwm_high_req <= 1'b0;
		cyc(3);
		chk(ls_gate_out, 1'b1);
		@(posedge clk);
		ls_current_reversed <= 1'b1;
		cyc(3);
		chk(ls_gate_out, 1'b0);
		set_mode(2'h0, 3'h4);
		ticks(8);
		chk(ls_gate_out, 1'b1);
		@(posedge clk);
		ls_current_reversed <= 1'b0;
	endtask
	task automatic t_fault(input int i);
		@(posedge clk);
		f[i] <= 1'b1;
		repeat (qn[i] - 1) @(posedge clk);
		f[i] <= 1'b0;
		cyc(3);
		chk(power_good_out, 1'b1);
		f[i] <= 1'b1;
		repeat (qn[i]) @(posedge clk);
		f[i] <= 1'b0;
		cyc(1);
		chk({power_good_out, hs_gate_oe, ls_gate_oe}, 3'h0);
		rdc(ADDR_STATE, 32'hF, 32'(1 << i), RESP_OKAY);
		wr(ADDR_MASK, 32'(1 << i), RESP_OKAY);
		cyc(1);
		chk(irq, 1'b1);
		wr(ADDR_STATUS, 32'(1 << i), RESP_OKAY);
		cyc(1);
		chk(irq, 1'b0);
		regulator_on <= 1'b0;
		@(posedge clk);
		regulator_on <= 1'b1;
		cyc(3);
		chk(power_good_out, 1'b1);
		rdc(ADDR_STATE, 32'hF, 32'h0, RESP_OKAY);
	endtask
	task automatic t_misc();
		@(posedge clk);
		thermistor_low <= 1'b1;
		near_target <= 1'b1;
		cyc(2);
		chk({thermal_throttle_n, power_good_out, slew_taper}, 3'h3);
		rdc(ADDR_STATUS, 32'h20, 32'h20, RESP_OKAY);
		thermistor_low <= 1'b0;
		near_target <= 1'b0;
		cyc(2);
		chk({thermal_throttle_n, slew_taper}, 2'h2);
	endtask
	task automatic t_wov();
		@(posedge clk);
		wov_above_cmp <= 1'b1;
		@(posedge clk);
		wov_above_cmp <= 1'b0;
		cyc(2);
		chk({ls_gate_out, ls_gate_oe, hs_gate_out, power_good_out}, 4'hC);
		wov_below_cmp <= 1'b1;
		cyc(3);
		chk({ls_gate_oe, hs_gate_oe, power_good_out}, 3'h0);
		wov_below_cmp <= 1'b0;
		regulator_on <= 1'b0;
		@(posedge clk);
		regulator_on <= 1'b1;
		cyc(3);
		chk(power_good_out, 1'b0);
		rdc(ADDR_STATE, 32'h10, 32'h10, RESP_OKAY);
		rst_b <= 1'b0;
		cyc(3);
		rst_b <= 1'b1;
		cyc(3);
		chk(power_good_out, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, f, voltage_code, sel} = '0;
		{cpu_sleep, raw_fde, regulator_on, pwm_high_req, ls_current_reversed, near_target} = '0;
		{wov_above_cmp, wov_below_cmp, thermistor_low} = '0;
		cpu_stop_n = 1'b1;
		s_axi_wstrb = 4'hF;
		err_total = 0;
		samples_checked = 0;
		qn = '{OC_QUAL_CYC, WOC_QUAL_CYC, VQ, VQ};
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		cyc(1);
		chk({power_good_out, thermal_throttle_n, mv}, 6'h12);
		rdc(ADDR_MASK, 32'h7F, {25'h0, MASK_RESET}, RESP_OKAY);
		wr(4'hC, 32'h1, RESP_SLVERR);
		wr(ADDR_STATE, 32'h1, RESP_SLVERR);
		rdc(4'hC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		regulator_on <= 1'b1;
		t_decode();
		t_misc();
		t_modes();
		t_diode();
		for (int i = 0; i < NUM_FAULTS; i++) t_fault(i);
		t_wov();
		end_of_test();
	end
endmodule
